// ### rtl/dfsr_top.sv
`timescale 1ns/100ps
module dfsr_top (
	// clock and hard reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// strap and switch pins
	input wire logic [5:0] pll_cfg_in,
	input wire logic halve_ratio_request_n_in,
	input wire logic quarter_ratio_request_n_in,
	// apb slave
	input wire dfsr_pkg::dfsr_apb_req_t apb_in,
	output dfsr_pkg::dfsr_apb_rsp_t apb_out,
	// ratio in effect
	output logic [5:0] ratio_status_field_out,
	output logic [2:0] mode_out
);

	// ****************************************
	// divide table
	// ****************************************
	// indexed by the strap code; reserved codes never divide
	function automatic dfsr_pkg::dfsr_entry_t dfsr_lookup(input logic [5:0] base);
		dfsr_pkg::dfsr_entry_t e;
		e = '0;
		case (base)
			6'h28: e = '{1'b1, 6'h10, 1'b0, 6'h00};
			6'h2C: e = '{1'b1, 6'h15, 1'b0, 6'h00};
			6'h24: e = '{1'b1, 6'h35, 1'b0, 6'h00};
			6'h34: e = '{1'b1, 6'h20, 1'b0, 6'h00};
			6'h14: e = '{1'b1, 6'h20, 1'b0, 6'h00};
			6'h08: e = '{1'b1, 6'h35, 1'b0, 6'h00};
			6'h04: e = '{1'b1, 6'h35, 1'b0, 6'h00};
			6'h30: e = '{1'b1, 6'h28, 1'b1, 6'h10};
			6'h18: e = '{1'b1, 6'h28, 1'b0, 6'h00};
			6'h1E: e = '{1'b1, 6'h1D, 1'b1, 6'h10};
			6'h1C: e = '{1'b1, 6'h1D, 1'b0, 6'h00};
			6'h2A: e = '{1'b1, 6'h2C, 1'b1, 6'h15};
			6'h22: e = '{1'b1, 6'h2C, 1'b0, 6'h00};
			6'h26: e = '{1'b1, 6'h24, 1'b1, 6'h15};
			6'h00: e = '{1'b1, 6'h24, 1'b0, 6'h00};
			6'h2E: e = '{1'b1, 6'h34, 1'b1, 6'h20};
			6'h3E: e = '{1'b1, 6'h34, 1'b0, 6'h00};
			6'h16: e = '{1'b1, 6'h14, 1'b1, 6'h20};
			6'h38: e = '{1'b1, 6'h14, 1'b0, 6'h00};
			6'h32: e = '{1'b1, 6'h08, 1'b1, 6'h35};
			6'h06: e = '{1'b1, 6'h04, 1'b1, 6'h35};
			6'h36: e = '{1'b1, 6'h30, 1'b1, 6'h28};
			6'h02: e = '{1'b1, 6'h18, 1'b1, 6'h28};
			6'h0A: e = '{1'b1, 6'h1E, 1'b1, 6'h1D};
			6'h0E: e = '{1'b1, 6'h2A, 1'b1, 6'h2C};
			6'h12: e = '{1'b1, 6'h22, 1'b0, 6'h00};
			default: e = '0;
		endcase
		return e;
	endfunction

	// ****************************************
	// strap capture
	// ****************************************
	logic [5:0] base_r;
	logic strap_taken_r;

	// caught by a clocked edge after release, never under the reset itself
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			base_r <= dfsr_pkg::DFSR_CODE_RESET;
			strap_taken_r <= 1'b0;
		end else if (!strap_taken_r) begin
			base_r <= pll_cfg_in;
			strap_taken_r <= 1'b1;
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] halve_sync_r;
	logic [1:0] quarter_sync_r;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			halve_sync_r <= dfsr_pkg::DFSR_SYNC_IDLE;
			quarter_sync_r <= dfsr_pkg::DFSR_SYNC_IDLE;
		end else begin
			halve_sync_r <= {halve_sync_r[0], halve_ratio_request_n_in};
			quarter_sync_r <= {quarter_sync_r[0], quarter_ratio_request_n_in};
		end
	end

	// ****************************************
	// request arbitration
	// ****************************************
	logic [1:0] ctl_r;
	logic pin_halve;
	logic pin_quarter;
	logic pin_ovr;
	logic pin_dis;
	dfsr_pkg::dfsr_mode_t want;
	dfsr_pkg::dfsr_mode_t mode_r;
	dfsr_pkg::dfsr_mode_t mode_nxt;
	dfsr_pkg::dfsr_entry_t ent;

	assign pin_halve = !halve_sync_r[1];
	assign pin_quarter = !quarter_sync_r[1];
	assign pin_ovr = pin_halve || pin_quarter;
	assign pin_dis = pin_halve && pin_quarter;
	assign ent = dfsr_lookup(base_r);

	always_comb begin
		want = dfsr_pkg::DFSR_FULL;
		if (pin_dis) begin
			want = dfsr_pkg::DFSR_FULL;
		end else if (pin_ovr) begin
			want = pin_quarter ? dfsr_pkg::DFSR_QUARTER : dfsr_pkg::DFSR_HALF;
		end else if (ctl_r[dfsr_pkg::DFSR_QUARTER_BIT]) begin
			want = dfsr_pkg::DFSR_QUARTER;
		end else if (ctl_r[dfsr_pkg::DFSR_HALVE_BIT]) begin
			want = dfsr_pkg::DFSR_HALF;
		end
	end

	// unsupported targets hold whatever mode is already running
	always_comb begin
		mode_nxt = mode_r;
		case (want)
			dfsr_pkg::DFSR_FULL: mode_nxt = dfsr_pkg::DFSR_FULL;
			dfsr_pkg::DFSR_HALF: begin
				if (ent.half_ok) begin
					mode_nxt = dfsr_pkg::DFSR_HALF;
				end
			end
			dfsr_pkg::DFSR_QUARTER: begin
				if (ent.quarter_ok) begin
					mode_nxt = dfsr_pkg::DFSR_QUARTER;
				end
			end
			default: mode_nxt = dfsr_pkg::DFSR_FULL;
		endcase
		if (!strap_taken_r) begin
			mode_nxt = dfsr_pkg::DFSR_FULL;
		end
	end

	// ****************************************
	// ratio state
	// ****************************************
	logic [5:0] ratio_nxt;

	always_comb begin
		case (mode_nxt)
			dfsr_pkg::DFSR_HALF: ratio_nxt = ent.half_code;
			dfsr_pkg::DFSR_QUARTER: ratio_nxt = ent.quarter_code;
			default: ratio_nxt = strap_taken_r ? base_r : pll_cfg_in;
		endcase
	end

	// one edge from request to new ratio, no idle gap between modes
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_r <= dfsr_pkg::DFSR_FULL;
			ratio_status_field_out <= dfsr_pkg::DFSR_CODE_RESET;
			mode_out <= dfsr_pkg::DFSR_FULL;
		end else begin
			mode_r <= mode_nxt;
			ratio_status_field_out <= ratio_nxt;
			mode_out <= mode_nxt;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	logic setup;
	logic wr_fire;
	logic hit_cfg;
	logic hit_diag;
	logic [31:0] rd_nxt;

	assign setup = apb_in.psel && !apb_in.penable;
	assign wr_fire = apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite;
	assign hit_cfg = apb_in.paddr == dfsr_pkg::DFSR_CFG_OFFSET;
	assign hit_diag = apb_in.paddr == dfsr_pkg::DFSR_DIAG_OFFSET;

	always_comb begin
		rd_nxt = '0;
		if (hit_cfg) begin
			rd_nxt[1:0] = ctl_r;
			rd_nxt[dfsr_pkg::DFSR_STATUS_LSB +: 6] = ratio_status_field_out;
		end else if (hit_diag) begin
			rd_nxt[dfsr_pkg::DFSR_BASE_LSB +: 6] = base_r;
			rd_nxt[dfsr_pkg::DFSR_MODE_LSB +: 3] = mode_r;
			rd_nxt[dfsr_pkg::DFSR_PIN_OVR_BIT] = pin_ovr;
			rd_nxt[dfsr_pkg::DFSR_PIN_DIS_BIT] = pin_dis;
		end
	end

	// ready answers in the first access cycle; no wait states
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			apb_out <= '0;
		end else begin
			apb_out.pready <= setup;
			apb_out.pslverr <= setup && !(hit_cfg || hit_diag);
			if (setup && !apb_in.pwrite) begin
				apb_out.prdata <= rd_nxt;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctl_r <= dfsr_pkg::DFSR_CTL_RESET;
		end else if (wr_fire && hit_cfg) begin
			ctl_r <= apb_in.pwdata[1:0];
		end
	end

endmodule

// ### rtl/dfsr_pkg.sv
package dfsr_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [31:0] DFSR_CFG_OFFSET = 32'h0000_0000;
	localparam logic [31:0] DFSR_DIAG_OFFSET = 32'h0000_0004;
	localparam int DFSR_HALVE_BIT = 0;
	localparam int DFSR_QUARTER_BIT = 1;
	localparam int DFSR_STATUS_LSB = 8;
	localparam int DFSR_BASE_LSB = 8;
	localparam int DFSR_MODE_LSB = 16;
	localparam int DFSR_PIN_OVR_BIT = 20;
	localparam int DFSR_PIN_DIS_BIT = 21;
	localparam logic [5:0] DFSR_CODE_RESET = 6'h00;
	localparam logic [1:0] DFSR_SYNC_IDLE = 2'h3;
	localparam logic [1:0] DFSR_CTL_RESET = 2'h0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		DFSR_FULL = 3'h1,
		DFSR_HALF = 3'h2,
		DFSR_QUARTER = 3'h4
	} dfsr_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} dfsr_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dfsr_apb_rsp_t;

	typedef struct packed {
		logic half_ok;
		logic [5:0] half_code;
		logic quarter_ok;
		logic [5:0] quarter_code;
	} dfsr_entry_t;

endpackage

// ### dv/dfsr_pin_model.sv
`timescale 1ns/100ps
module dfsr_pin_model (
	// clock
	input wire logic clk_sys_in,
	// requests from system logic
	input wire logic halve_on_in,
	input wire logic quarter_on_in,
	// active-low switch pins
	output logic halve_ratio_request_n_out = 1'b1,
	output logic quarter_ratio_request_n_out = 1'b1
);
	// launched on the core edge, in step with it
	// requests pass straight through, whatever the ratio
	always @(posedge clk_sys_in) begin
		halve_ratio_request_n_out <= !halve_on_in;
		quarter_ratio_request_n_out <= !quarter_on_in;
	end
endmodule

// ### dv/dfsr_assertions.sv
`timescale 1ns/100ps
module dfsr_assertions (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// strap and pins
	input wire logic [5:0] pll_cfg_in,
	input wire logic halve_ratio_request_n_in,
	input wire logic quarter_ratio_request_n_in,
	// apb
	input wire dfsr_pkg::dfsr_apb_req_t apb_in,
	input wire dfsr_pkg::dfsr_apb_rsp_t apb_out,
	// ratio
	input wire logic [5:0] ratio_status_field_out,
	input wire logic [2:0] mode_out
);
	logic [1:0] cnt_r;
	logic [5:0] base_r;
	wire logic h = halve_ratio_request_n_in;
	wire logic q = quarter_ratio_request_n_in;
	// guard keeps the strap-capture edge out of every check but the one-hot and pin checks
	wire logic up = (cnt_r == 2'h2);
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			cnt_r <= 2'h0;
		else if (!up)
			cnt_r <= cnt_r + 2'h1;
	end
	always_ff @(posedge clk_sys_in) begin
		if (cnt_r == 2'h0)
			base_r <= pll_cfg_in;
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	sequence s_both_low;
		(!h && !q)[*3];
	endsequence
	sequence s_halve_only;
		(!h && q)[*3];
	endsequence
	a_mode_onehot: assert property ($onehot(mode_out))
		else $error("mode not one-hot");
	a_both_pins_full: assert property (s_both_low |=> mode_out == dfsr_pkg::DFSR_FULL)
		else $error("both pins low but divided");
	a_halve_pin_wins: assert property (s_halve_only |=> mode_out != dfsr_pkg::DFSR_QUARTER)
		else $error("halve pin did not override");
	a_full_shows_base: assert property (up && mode_out == dfsr_pkg::DFSR_FULL |->
		ratio_status_field_out == base_r) else $error("full status not base");
	a_status_tracks_mode: assert property (up && $changed(ratio_status_field_out) |->
		$changed(mode_out)) else $error("status moved without mode change");
	a_half_differs: assert property (up && mode_out == dfsr_pkg::DFSR_HALF |->
		ratio_status_field_out != base_r) else $error("half shows base code");
	a_base_no_divide: assert property (up && (base_r == 6'h10 || base_r == 6'h20) |->
		mode_out == dfsr_pkg::DFSR_FULL) else $error("2x or 3x base divided");
	a_four_no_quarter: assert property (up && base_r == 6'h28 |->
		mode_out != dfsr_pkg::DFSR_QUARTER) else $error("4x base in quarter");
	a_eight_quarter: assert property (up && base_r == 6'h30 && mode_out[2] |->
		ratio_status_field_out == 6'h10) else $error("8x quarter code wrong");
endmodule

// ### dv/tb_dfsr_top.sv
`timescale 1ns/100ps
module tb_dfsr_top;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [5:0] pll_cfg_in = 6'h30;
	logic hon = 1'b0;
	logic qon = 1'b0;
	logic halve_n;
	logic quarter_n;
	dfsr_pkg::dfsr_apb_req_t apb_in = '0;
	dfsr_pkg::dfsr_apb_rsp_t apb_out;
	logic [5:0] ratio_status_field_out;
	logic [2:0] mode_out;
	logic [31:0] rd;
	logic er;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	logic [5:0] tb_base [8] = '{6'h10, 6'h28, 6'h2c, 6'h30, 6'h1e, 6'h2a, 6'h3f, 6'h0e};
	logic [5:0] tb_half [8] = '{6'h10, 6'h10, 6'h15, 6'h28, 6'h1d, 6'h2c, 6'h3f, 6'h2a};
	// unsupported quarter from half holds half
	logic [5:0] tb_quar [8] = '{6'h10, 6'h10, 6'h15, 6'h10, 6'h10, 6'h15, 6'h3f, 6'h2c};
	// one-hot mode: 1 full, 2 half, 4 quarter
	logic [2:0] tb_hm [8] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h2};
	logic [2:0] tb_qm [8] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h1, 3'h4};
	dfsr_top dfsr_top_i (.clk_sys_in, .rstn_in, .pll_cfg_in, .halve_ratio_request_n_in(halve_n),
		.quarter_ratio_request_n_in(quarter_n), .apb_in, .apb_out, .ratio_status_field_out,
		.mode_out);
	dfsr_pin_model dfsr_pin_model_i (.clk_sys_in, .halve_on_in(hon), .quarter_on_in(qon),
		.halve_ratio_request_n_out(halve_n), .quarter_ratio_request_n_out(quarter_n));
	always #25 clk_sys_in = ~clk_sys_in;
	task automatic stop_test;
		$display("fails %0d checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc > 5000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		apb_in <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys_in);
		apb_in.penable <= 1'b1;
		do @(posedge clk_sys_in); while (apb_out.pready !== 1'b1);
		rd = apb_out.prdata;
		er = apb_out.pslverr;
		apb_in <= '0;
	endtask
	// wait covers the model's launch edge, two sync stages and the state edge
	task automatic chk(input logic [5:0] e, input logic [2:0] m);
		repeat (5) @(posedge clk_sys_in);
		cmp("status", {26'h0, e}, {26'h0, ratio_status_field_out});
		cmp("mode", {29'h0, m}, {29'h0, mode_out});
		apb(1'b0, dfsr_pkg::DFSR_CFG_OFFSET, '0);
		cmp("status read", {26'h0, e}, {26'h0, rd[13:8]});
		apb(1'b0, dfsr_pkg::DFSR_DIAG_OFFSET, '0);
		cmp("mode read", {29'h0, m}, {29'h0, rd[18:16]});
	endtask
	initial begin
		for (int i = 0; i < 8; i++) begin
			rstn_in <= 1'b0;
			pll_cfg_in <= tb_base[i];
			repeat (6) @(posedge clk_sys_in);
			rstn_in <= 1'b1;
			chk(tb_base[i], 3'h1);
			apb(1'b1, dfsr_pkg::DFSR_CFG_OFFSET, 32'h0000_0001);
			chk(tb_half[i], tb_hm[i]);
			apb(1'b1, dfsr_pkg::DFSR_CFG_OFFSET, 32'h0000_0003);
			chk(tb_quar[i], tb_qm[i]);
			apb(1'b1, dfsr_pkg::DFSR_CFG_OFFSET, '0);
			chk(tb_base[i], 3'h1);
		end
		apb(1'b1, dfsr_pkg::DFSR_CFG_OFFSET, 32'h0000_0002);
		chk(6'h2c, 3'h4);
		hon <= 1'b1;
		chk(6'h2a, 3'h2);
		qon <= 1'b1;
		chk(6'h0e, 3'h1);
		hon <= 1'b0;
		apb(1'b1, dfsr_pkg::DFSR_CFG_OFFSET, 32'h0000_0001);
		chk(6'h2c, 3'h4);
		qon <= 1'b0;
		chk(6'h2a, 3'h2);
		apb(1'b0, 32'h0000_0008, '0);
		cmp("unmapped error", 32'h0000_0001, {31'h0, er});
		cmp("unmapped data", 32'h0000_0000, rd);
		stop_test();
	end
endmodule
bind dfsr_top dfsr_assertions dfsr_assertions_i (.clk_sys_in, .rstn_in, .pll_cfg_in,
	.halve_ratio_request_n_in, .quarter_ratio_request_n_in, .apb_in, .apb_out,
	.ratio_status_field_out, .mode_out);
